// [logic/scl_defines.svh]
// Constants for the strap configuration latch: codes, field positions, map
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

`define SCL_MODE_W          4
`define SCL_ADDR_W          5
`define SCL_ADDR_LO_W       3
`define SCL_ADDR_HI_ZERO    2'h0

`define SCL_MODE_NAND       4'h4
`define SCL_MODE_PWRDN      4'h7
`define SCL_MODE_1000FD     4'hc
`define SCL_MODE_1000       4'hd
`define SCL_MODE_NO1000HD   4'he
`define SCL_MODE_ALL        4'hf

`define SCL_BUS_AW          4
`define SCL_BUS_DW          32
`define SCL_OFS_CFG         4'h0
`define SCL_OFS_ADV         4'h4
`define SCL_OFS_CTRL        4'h8

`define SCL_CFG_MODE_LSB    0
`define SCL_CFG_REFCLK_BIT  4
`define SCL_CFG_LED_BIT     5
`define SCL_CFG_ADDR_LSB    8
`define SCL_CFG_VALID_BIT   16
`define SCL_CTRL_HOLD_BIT   0

`define SCL_CTRL_RST        1'h0
`define SCL_WORD_RST        32'h0000_0000
`define SCL_BIT_RST         1'h0

`endif

// [logic/scl_pkg.sv]
// Types and advertisement decode for the strap configuration latch
`include "scl_defines.svh"

package scl_pkg;

   typedef enum logic {SCL_ST_ARMED, SCL_ST_HELD} scl_cap_state_e;

   // First field is the most significant bit of the packed word
   typedef struct packed {
      logic reserved;
      logic nand_tree;
      logic power_down;
      logic rgmii;
      logic a1000fd;
      logic a1000hd;
      logic a100fd;
      logic a100hd;
      logic a10fd;
      logic a10hd;
   } scl_adv_s;

   typedef struct packed {
      logic [`SCL_MODE_W-1:0]    mode;
      logic                      ref_clk;
      logic                      led_single;
      logic [`SCL_ADDR_LO_W-1:0] addr;
      scl_adv_s                  adv;
   } scl_cfg_s;

   function automatic scl_adv_s scl_adv_decode(input logic [`SCL_MODE_W-1:0] m);
      scl_adv_s a;
      a = '0;
      case (m)
         `SCL_MODE_1000FD:
         begin
            a.rgmii   = 1'b1;
            a.a1000fd = 1'b1;
         end
         `SCL_MODE_1000:
         begin
            a.rgmii   = 1'b1;
            a.a1000fd = 1'b1;
            a.a1000hd = 1'b1;
         end
         `SCL_MODE_NO1000HD:
         begin
            a         = '1;
            a.a1000hd = 1'b0;
            a.power_down = 1'b0;
            a.nand_tree  = 1'b0;
            a.reserved   = 1'b0;
         end
         `SCL_MODE_ALL:
         begin
            a            = '1;
            a.power_down = 1'b0;
            a.nand_tree  = 1'b0;
            a.reserved   = 1'b0;
         end
         `SCL_MODE_PWRDN: a.power_down = 1'b1;
         `SCL_MODE_NAND:  a.nand_tree  = 1'b1;
         default:         a.reserved   = 1'b1;
      endcase
      return a;
   endfunction

endpackage

// [logic/scl_cfg_if.sv]
// Carrier for the captured configuration between capture unit and top
`timescale 1ns/1ps

interface scl_cfg_if;
   import scl_pkg::*;
   scl_cfg_s cap;
   logic     valid;
   modport src (output cap, output valid);
   modport dst (input cap, input valid);
endinterface

// [logic/scl_strap_capture.sv]
// Strap capture unit: samples the straps once on release of reset
`timescale 1ns/1ps
`include "scl_defines.svh"

module scl_strap_capture
   import scl_pkg::*;
(
   input  wire logic                      i_clk_sys,               // System clock
   input  wire logic                      i_rst,                   // Sync reset, high
   input  wire logic [`SCL_MODE_W-1:0]    i_op_select_strap,       // Operating select
   input  wire logic                      i_ref_clock_out_strap,   // Ref clock enable
   input  wire logic                      i_indicator_style_strap, // LED style
   input  wire logic [`SCL_ADDR_LO_W-1:0] i_station_address_strap, // Address low bits
   scl_cfg_if.src                         cfg                      // Captured config
);

   scl_cap_state_e state_q;
   scl_cap_state_e state_d;
   scl_cfg_s       cap_q;
   scl_cfg_s       cap_d;
   logic           valid_q;

   // Reset cannot load pin levels, so the sample is taken on the first edge after release
   assign cap_d.mode       = i_op_select_strap;                  // [RQ5]
   assign cap_d.ref_clk    = i_ref_clock_out_strap;              // [RQ3]
   assign cap_d.led_single = i_indicator_style_strap;            // [RQ4]
   assign cap_d.addr       = i_station_address_strap;            // [RQ8]
   assign cap_d.adv        = scl_adv_decode(i_op_select_strap);  // [RQ1] [RQ2] [RQ7]

   always_comb
   begin
      case (state_q)
         SCL_ST_ARMED: state_d = SCL_ST_HELD;
         SCL_ST_HELD:  state_d = SCL_ST_HELD;
         default:      state_d = SCL_ST_ARMED;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         state_q <= SCL_ST_ARMED;
         cap_q   <= '0;
         valid_q <= `SCL_BIT_RST;
      end
      else
      begin
         state_q <= state_d;
         if (state_q == SCL_ST_ARMED)
         begin
            cap_q   <= cap_d;     // [RQ9]
            valid_q <= 1'b1;
         end
      end
   end

   assign cfg.cap   = cap_q;
   assign cfg.valid = valid_q;

endmodule

// [logic/scl_strap_config_latch.sv]
// Strap configuration latch top: capture, decoded outputs, Avalon-MM registers
//
// Functional notes
// RQ1: Code 1100 advertises 1000Base-T full duplex only, 1101 full and half, both RGMII.
// RQ2: Code 1110 advertises all 10/100/1000 abilities but 1000 half, 1111 all, RGMII.
// RQ3: The ref clock strap, taken at reset, turns the 125 MHz clock output on when high.
// RQ4: The LED style strap, taken at reset, selects single LED when high, dual when low.
// RQ5: All straps are captured only at power-up or reset and then used as configuration.
// RQ6: Boards whose MAC may drive shared strap pins during reset should add pull resistors.
// RQ7: Code 0111 selects power-down, 0100 the NAND tree test, other low codes are reserved.
// RQ8: The three address straps give address bits 2:0, and bits 4:3 are forced to zero.
// RQ9: Captured values are registered on reset release and held until the next reset.
`timescale 1ns/1ps
`include "scl_defines.svh"

module scl_strap_config_latch
   import scl_pkg::*;
(
   input  wire logic                      i_clk_sys,               // 100 MHz clock
   input  wire logic                      i_rst,                   // Sync reset, high
   input  wire logic [`SCL_MODE_W-1:0]    i_op_select_strap,       // Operating select
   input  wire logic                      i_ref_clock_out_strap,   // Ref clock strap
   input  wire logic                      i_indicator_style_strap, // LED style strap
   input  wire logic [`SCL_ADDR_LO_W-1:0] i_station_address_strap, // Address straps
   input  wire logic [`SCL_BUS_AW-1:0]    i_avs_address,           // Byte address
   input  wire logic                      i_avs_read,              // Read request
   input  wire logic                      i_avs_write,             // Write request
   input  wire logic [`SCL_BUS_DW-1:0]    i_avs_writedata,         // Write data
   input  wire logic [3:0]                i_avs_byteenable,        // Byte lanes
   output logic      [`SCL_BUS_DW-1:0]    o_avs_readdata,          // Read data
   output logic                           o_avs_waitrequest,       // Stall
   output logic                           o_cfg_valid,             // Config captured
   output logic      [`SCL_MODE_W-1:0]    o_op_select,             // Captured code
   output logic                           o_rgmii_mode,            // RGMII operation
   output logic                           o_power_down,            // Chip power-down
   output logic                           o_nand_tree_test,        // NAND tree test
   output logic                           o_reserved_mode,         // Unused code
   output logic                           o_adv_10_hd,             // Advertise 10 half
   output logic                           o_adv_10_fd,             // Advertise 10 full
   output logic                           o_adv_100_hd,            // Advertise 100 half
   output logic                           o_adv_100_fd,            // Advertise 100 full
   output logic                           o_adv_1000_hd,           // Advertise 1000 half
   output logic                           o_adv_1000_fd,           // Advertise 1000 full
   output logic                           o_ref_clock_out_pin_en,  // 125 MHz out on
   output logic                           o_single_indicator_style_strap,       // 1 single, 0 dual
   output logic      [`SCL_ADDR_W-1:0]    o_station_address        // Station address
);

   scl_cfg_if cfg ();

   scl_strap_capture u_capture (
      .i_clk_sys               (i_clk_sys),
      .i_rst                   (i_rst),
      .i_op_select_strap       (i_op_select_strap),
      .i_ref_clock_out_strap   (i_ref_clock_out_strap),
      .i_indicator_style_strap (i_indicator_style_strap),
      .i_station_address_strap (i_station_address_strap),
      .cfg                     (cfg.src)
   );

   // Captured configuration straight from the capture flops
   assign o_cfg_valid       = cfg.valid;
   assign o_op_select       = cfg.cap.mode;
   assign o_rgmii_mode      = cfg.cap.adv.rgmii;        // [RQ1] [RQ2]
   assign o_power_down      = cfg.cap.adv.power_down;   // [RQ7]
   assign o_nand_tree_test  = cfg.cap.adv.nand_tree;    // [RQ7]
   assign o_reserved_mode   = cfg.cap.adv.reserved;
   assign o_adv_10_hd       = cfg.cap.adv.a10hd;        // [RQ2]
   assign o_adv_10_fd       = cfg.cap.adv.a10fd;
   assign o_adv_100_hd      = cfg.cap.adv.a100hd;
   assign o_adv_100_fd      = cfg.cap.adv.a100fd;
   assign o_adv_1000_hd     = cfg.cap.adv.a1000hd;      // [RQ1]
   assign o_adv_1000_fd     = cfg.cap.adv.a1000fd;
   assign o_single_indicator_style_strap = cfg.cap.led_single;       // [RQ4]
   assign o_station_address = {`SCL_ADDR_HI_ZERO, cfg.cap.addr};  // [RQ8]

   // Register bus: one wait cycle per access, answer on the following edge
   logic                   ack_q;
   logic                   ctrl_hold_q;
   logic                   ref_en_q;
   logic [`SCL_BUS_DW-1:0] rdata_q;

   wire                    req      = i_avs_read | i_avs_write;
   wire                    first    = req & ~ack_q;
   wire                    take     = req & ack_q;
   wire                    hit_cfg  = (i_avs_address == `SCL_OFS_CFG);
   wire                    hit_adv  = (i_avs_address == `SCL_OFS_ADV);
   wire                    hit_ctrl = (i_avs_address == `SCL_OFS_CTRL);
   wire                    ctrl_we  = take & i_avs_write & hit_ctrl & i_avs_byteenable[0];
   wire                    ref_en_d = cfg.cap.ref_clk & cfg.valid & ~ctrl_hold_q;

   wire [`SCL_BUS_DW-1:0]  cfg_word =
      (`SCL_BUS_DW'(cfg.cap.mode)       << `SCL_CFG_MODE_LSB)   |
      (`SCL_BUS_DW'(cfg.cap.ref_clk)    << `SCL_CFG_REFCLK_BIT) |
      (`SCL_BUS_DW'(cfg.cap.led_single) << `SCL_CFG_LED_BIT)    |
      (`SCL_BUS_DW'(o_station_address)  << `SCL_CFG_ADDR_LSB)   |
      (`SCL_BUS_DW'(cfg.valid)          << `SCL_CFG_VALID_BIT);
   wire [`SCL_BUS_DW-1:0]  adv_word  = `SCL_BUS_DW'(cfg.cap.adv);
   wire [`SCL_BUS_DW-1:0]  ctrl_word = `SCL_BUS_DW'(ctrl_hold_q) << `SCL_CTRL_HOLD_BIT;

   // Unmapped offsets read as zero and swallow writes
   wire [`SCL_BUS_DW-1:0]  rd_mux =
      hit_cfg  ? cfg_word  :
      hit_adv  ? adv_word  :
      hit_ctrl ? ctrl_word : `SCL_WORD_RST;

   assign o_avs_waitrequest      = first;
   assign o_avs_readdata         = rdata_q;
   assign o_ref_clock_out_pin_en = ref_en_q;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         ack_q <= `SCL_BIT_RST;
      else
         ack_q <= first;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         rdata_q <= `SCL_WORD_RST;
      else if (first & i_avs_read)
         rdata_q <= rd_mux;
   end

   // Software may hold the clock output off; it cannot turn on a strapped-off clock
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         ctrl_hold_q <= `SCL_CTRL_RST;
      else if (ctrl_we)
         ctrl_hold_q <= i_avs_writedata[`SCL_CTRL_HOLD_BIT];
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         ref_en_q <= `SCL_BIT_RST;
      else
         ref_en_q <= ref_en_d;   // [RQ3]
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   a_cap_on_release: assert property ( // [RQ5]
      $fell(i_rst) |=> o_cfg_valid && (o_op_select == $past(i_op_select_strap)))
      else $error("straps not captured on reset release");

   a_cfg_held_stable: assert property ( // [RQ9]
      o_cfg_valid |=> o_cfg_valid && $stable(o_op_select) && $stable(o_station_address)
                      && $stable(o_single_indicator_style_strap) && $stable(o_rgmii_mode))
      else $error("captured configuration changed after capture");

   a_adv_1000_fd: assert property ( // [RQ1]
      o_cfg_valid && (o_op_select == `SCL_MODE_1000FD)
      |-> o_rgmii_mode && o_adv_1000_fd && !o_adv_1000_hd && !o_adv_100_fd
          && !o_adv_100_hd && !o_adv_10_fd && !o_adv_10_hd)
      else $error("code 1100 advertisement wrong");

   a_adv_1000_both: assert property ( // [RQ1]
      o_cfg_valid && (o_op_select == `SCL_MODE_1000)
      |-> o_rgmii_mode && o_adv_1000_fd && o_adv_1000_hd && !o_adv_100_fd
          && !o_adv_100_hd && !o_adv_10_fd && !o_adv_10_hd)
      else $error("code 1101 advertisement wrong");

   a_adv_no_1000hd: assert property ( // [RQ2]
      o_cfg_valid && (o_op_select == `SCL_MODE_NO1000HD)
      |-> o_rgmii_mode && o_adv_1000_fd && !o_adv_1000_hd && o_adv_100_fd
          && o_adv_100_hd && o_adv_10_fd && o_adv_10_hd)
      else $error("code 1110 advertisement wrong");

   a_adv_all_caps: assert property ( // [RQ2]
      o_cfg_valid && (o_op_select == `SCL_MODE_ALL)
      |-> o_rgmii_mode && o_adv_1000_fd && o_adv_1000_hd && o_adv_100_fd
          && o_adv_100_hd && o_adv_10_fd && o_adv_10_hd)
      else $error("code 1111 advertisement wrong");

   a_refclk_from_strap: assert property ( // [RQ3]
      $fell(i_rst) |-> ##2 (o_ref_clock_out_pin_en == $past(i_ref_clock_out_strap, 2)))
      else $error("reference clock output does not follow its strap");

   a_refclk_off_low: assert property ( // [RQ3]
      o_cfg_valid && !$past(cfg.cap.ref_clk) |-> !o_ref_clock_out_pin_en)
      else $error("reference clock output on with strap low");

   a_led_style_cap: assert property ( // [RQ4]
      $fell(i_rst) |=> (o_single_indicator_style_strap == $past(i_indicator_style_strap)))
      else $error("LED style not captured");

   a_mode_power_down: assert property ( // [RQ7]
      o_cfg_valid |-> (o_power_down == (o_op_select == `SCL_MODE_PWRDN))
                      && (o_nand_tree_test == (o_op_select == `SCL_MODE_NAND))
                      && !(o_power_down && (o_rgmii_mode || o_adv_1000_fd)))
      else $error("power-down or test mode decode wrong");

   a_addr_upper_zero: assert property ( // [RQ8]
      o_station_address[`SCL_ADDR_W-1:`SCL_ADDR_LO_W] == `SCL_ADDR_HI_ZERO)
      else $error("upper station address bits not zero");

   a_addr_low_cap: assert property ( // [RQ8]
      $fell(i_rst) |=> (o_station_address[`SCL_ADDR_LO_W-1:0]
                         == $past(i_station_address_strap)))
      else $error("station address not captured");

   a_bus_one_wait: assert property (
      req && !ack_q |-> o_avs_waitrequest ##1 (!req || !o_avs_waitrequest))
      else $error("register access stalled longer than one cycle");

   a_ctrl_gates_clk: assert property (
      ctrl_hold_q |=> !o_ref_clock_out_pin_en)
      else $error("software hold did not stop the clock output");

   a_refclk_on_high: assert property ( // [RQ3]
      o_cfg_valid && $past(o_cfg_valid)
      && $past(cfg.cap.ref_clk) && !$past(ctrl_hold_q)
      |-> o_ref_clock_out_pin_en)
      else $error("clock output off with strap high");

   a_refclk_idle_off: assert property ( // [RQ3]
      !o_cfg_valid |-> !o_ref_clock_out_pin_en)
      else $error("clock output on before capture");

   a_valid_one_edge: assert property ( // [RQ5]
      $fell(i_rst) |-> !o_cfg_valid ##1 o_cfg_valid)
      else $error("capture not done one edge after release");

   a_rgmii_codes: assert property ( // [RQ1] [RQ2]
      o_cfg_valid
      |-> o_rgmii_mode == (o_op_select >= `SCL_MODE_1000FD))
      else $error("RGMII flag does not match the code");

   a_reserved_quiet: assert property ( // [RQ7]
      o_cfg_valid && o_reserved_mode
      |-> !o_rgmii_mode
          && !o_power_down
          && !o_nand_tree_test
          && !o_adv_1000_fd
          && !o_adv_1000_hd
          && !o_adv_100_fd
          && !o_adv_100_hd
          && !o_adv_10_fd
          && !o_adv_10_hd)
      else $error("reserved code selects a mode");

   a_nand_quiet: assert property ( // [RQ7]
      o_cfg_valid && o_nand_tree_test
      |-> !o_rgmii_mode && !o_power_down && !o_reserved_mode
          && !o_adv_1000_fd && !o_adv_100_fd && !o_adv_10_fd)
      else $error("test mode code selects another mode");

   a_cap_fields_held: assert property ( // [RQ9]
      o_cfg_valid |=> $stable(cfg.cap.ref_clk) && $stable(cfg.cap.adv))
      else $error("captured clock strap or advertisement changed");

   a_wait_needs_req: assert property (
      !req |-> !o_avs_waitrequest)
      else $error("waitrequest raised with no access");

   a_ack_then_idle: assert property (
      req && ack_q |=> !ack_q)
      else $error("access acknowledged twice in a row");

   a_rd_latched: assert property (
      first && i_avs_read
      |=> o_avs_readdata == $past(rd_mux))
      else $error("read data not loaded at first edge");

   a_rd_unmapped: assert property (
      first && i_avs_read && !hit_cfg && !hit_adv && !hit_ctrl
      |=> o_avs_readdata == `SCL_WORD_RST)
      else $error("unmapped read not zero");

   a_rd_cfg_valid: assert property ( // [RQ5]
      first && i_avs_read && hit_cfg && o_cfg_valid
      |=> o_avs_readdata[`SCL_CFG_VALID_BIT])
      else $error("configuration word lost its valid bit");

   a_rdata_stands: assert property (
      !(first && i_avs_read) |=> $stable(o_avs_readdata))
      else $error("read data changed with no new read");

   a_ctrl_write_lands: assert property (
      ctrl_we |=> ctrl_hold_q == $past(i_avs_writedata[`SCL_CTRL_HOLD_BIT]))
      else $error("control write did not land");

   a_ctrl_lane_off: assert property (
      take && i_avs_write && hit_ctrl && !i_avs_byteenable[0]
      |=> $stable(ctrl_hold_q))
      else $error("control write landed with lane off");

   a_ro_regs_kept: assert property ( // [RQ9]
      take && i_avs_write && (hit_cfg || hit_adv)
      |=> $stable(cfg.cap) && $stable(ctrl_hold_q))
      else $error("write to read-only register changed state");

   c_cap_all_caps: cover property ($fell(i_rst) ##1 o_adv_1000_hd && o_adv_10_hd);
   c_cap_power_down: cover property ($fell(i_rst) ##1 o_power_down);
   c_bus_read: cover property (i_avs_read && !o_avs_waitrequest && hit_cfg);
   c_ctrl_hold: cover property (ctrl_we ##2 !o_ref_clock_out_pin_en && cfg.cap.ref_clk);
   c_reserved_code: cover property ($fell(i_rst) ##1 o_reserved_mode);

endmodule

// [tb/scl_strap_board.sv]
// Board strap resistors plus an attached MAC that drives the shared strap pins
`timescale 1ns/1ps

module scl_strap_board
(
   input  wire logic       i_clk_sys,               // System clock
   input  wire logic       i_rst,                   // Device reset, high
   input  wire logic [3:0] i_mode,                  // Intended operating select
   input  wire logic       i_ref,                   // Intended ref clock strap
   input  wire logic       i_led,                   // Intended LED style
   input  wire logic [2:0] i_addr,                  // Intended station address
   output logic      [3:0] o_op_select_strap,       // Operating select pins
   output logic            o_ref_clock_out_strap,   // Ref clock strap pin
   output logic            o_indicator_style_strap, // LED style pin
   output logic      [2:0] o_station_address_strap  // Address strap pins
);
   logic       mac_on_q = 1'b0;
   logic [8:0] junk_q   = 9'h000;
   wire  logic [8:0] intent;
   wire  logic [8:0] pins;

   // MAC wakes on the edge after reset release, so its noise never meets capture
   always_ff @(posedge i_clk_sys)
   begin
      mac_on_q <= ~i_rst;
      junk_q   <= junk_q + 9'h001;
   end

   assign intent = {i_mode, i_ref, i_led, i_addr};
   // Pulls set the level through reset; afterwards the MAC toggles the lines
   assign pins = mac_on_q ? (~intent ^ junk_q) : intent;
   assign {o_op_select_strap, o_ref_clock_out_strap, o_indicator_style_strap,
           o_station_address_strap} = pins;
endmodule

// [tb/testbench.sv]
// Self-checking bench for the strap configuration latch
`timescale 1ns/1ps
`include "scl_defines.svh"

module testbench;
   import scl_pkg::*;

   typedef struct packed {
      logic [3:0] mode;
      logic       rf;
      logic       led;
      logic [2:0] addr;
   } scl_tb_cap_s;

   logic        i_clk_sys = 1'b0;
   logic        i_rst     = 1'b1;
   logic [3:0]  i_avs_address    = 4'h0;
   logic        i_avs_read       = 1'b0;
   logic        i_avs_write      = 1'b0;
   logic [31:0] i_avs_writedata  = 32'h0000_0000;
   logic [3:0]  i_avs_byteenable = 4'h0;
   logic [31:0] o_avs_readdata;
   logic        o_avs_waitrequest, o_cfg_valid, o_rgmii_mode, o_power_down;
   logic        o_nand_tree_test, o_reserved_mode, o_adv_10_hd, o_adv_10_fd;
   logic        o_adv_100_hd, o_adv_100_fd, o_adv_1000_hd, o_adv_1000_fd;
   logic        o_ref_clock_out_pin_en, o_single_indicator_style_strap;
   logic [3:0]  o_op_select, op_strap, b_mode = 4'h0;
   logic [4:0]  o_station_address;
   logic [2:0]  addr_strap, b_addr = 3'h0;
   logic        ref_strap, led_strap, b_ref = 1'b0, b_led = 1'b0, v1 = 1'b0, v2 = 1'b0;
   logic [31:0] seed = 32'hde5a_9abf;
   logic [31:0] cfg_exp, adv_exp;
   wire  logic [9:0] adv_seen;
   scl_tb_cap_s cap_q[$];
   scl_tb_cap_s c;
   logic [31:0] rd_q[$];
   int          fails = 0;
   int          tests_run = 0;

   always #5 i_clk_sys = ~i_clk_sys;

   assign adv_seen = {o_reserved_mode, o_nand_tree_test, o_power_down, o_rgmii_mode,
                      o_adv_1000_fd, o_adv_1000_hd, o_adv_100_fd, o_adv_100_hd,
                      o_adv_10_fd, o_adv_10_hd};

   scl_strap_board board (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mode(b_mode),
      .i_ref(b_ref), .i_led(b_led), .i_addr(b_addr), .o_op_select_strap(op_strap),
      .o_ref_clock_out_strap(ref_strap), .o_indicator_style_strap(led_strap),
      .o_station_address_strap(addr_strap));

   scl_strap_config_latch dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_op_select_strap(op_strap), .i_ref_clock_out_strap(ref_strap),
      .i_indicator_style_strap(led_strap), .i_station_address_strap(addr_strap),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .o_cfg_valid(o_cfg_valid), .o_op_select(o_op_select), .o_rgmii_mode(o_rgmii_mode),
      .o_power_down(o_power_down), .o_nand_tree_test(o_nand_tree_test),
      .o_reserved_mode(o_reserved_mode), .o_adv_10_hd(o_adv_10_hd),
      .o_adv_10_fd(o_adv_10_fd), .o_adv_100_hd(o_adv_100_hd), .o_adv_100_fd(o_adv_100_fd),
      .o_adv_1000_hd(o_adv_1000_hd), .o_adv_1000_fd(o_adv_1000_fd),
      .o_ref_clock_out_pin_en(o_ref_clock_out_pin_en),
      .o_single_indicator_style_strap(o_single_indicator_style_strap), .o_station_address(o_station_address));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Bit order follows the advertisement register: reserved down to 10 half
   function automatic logic [9:0] exp_adv(input logic [3:0] m);
      case (m)
         `SCL_MODE_1000FD:   return 10'h060;
         `SCL_MODE_1000:     return 10'h070;
         `SCL_MODE_NO1000HD: return 10'h06f;
         `SCL_MODE_ALL:      return 10'h07f;
         `SCL_MODE_PWRDN:    return 10'h080;
         `SCL_MODE_NAND:     return 10'h100;
         default:            return 10'h200;
      endcase
   endfunction

   task automatic complete_run;
      if (fails == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmp_bit(input string what, input logic e, input logic g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %b seen %b", what, e, g);
      end
   endtask

   // Request held until waitrequest is sampled low, then one idle edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      i_avs_address    <= a;
      i_avs_writedata  <= d;
      i_avs_byteenable <= be;
      i_avs_write      <= wr;
      i_avs_read       <= ~wr;
      // No wait limit here: only the watchdog ends a stalled access
      do
         @(posedge i_clk_sys);
      while (o_avs_waitrequest !== 1'b0);
      i_avs_read  <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clk_sys);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
   endtask

   // Watcher: read data at the accepting edge, captured outputs one edge after valid
   always @(posedge i_clk_sys)
   begin
      if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0 && rd_q.size() > 0)
         cmp_word("readdata", rd_q.pop_front(), o_avs_readdata);
      if (v1 && !v2 && cap_q.size() > 0)
      begin
         c = cap_q.pop_front();
         cmp_word("op_select", 32'(c.mode), 32'(o_op_select));
         cmp_word("advertise", 32'(exp_adv(c.mode)), 32'(adv_seen));
         cmp_bit("ref_clock_en", c.rf, o_ref_clock_out_pin_en);
         cmp_bit("single_led", c.led, o_single_indicator_style_strap);
         cmp_word("station_address", 32'({2'h0, c.addr}), 32'(o_station_address));
      end
      v2 = v1;
      v1 = (o_cfg_valid === 1'b1);
   end

   initial
   begin
      repeat (20000) @(posedge i_clk_sys);
      fails++;
      complete_run();
   end

   initial
   begin
      for (int k = 0; k < 16; k++)
      begin
         seed = lfsr(seed);
         b_mode <= 4'(k);
         b_addr <= seed[2:0];
         b_ref  <= (k == 15) ? 1'b1 : seed[3];
         b_led  <= seed[4];
         i_rst  <= 1'b1;
         repeat ((k == 0) ? 12 : 3) @(posedge i_clk_sys);
         cap_q.push_back({4'(k), (k == 15) ? 1'b1 : seed[3], seed[4], seed[2:0]});
         cfg_exp = {15'h0000, 1'b1, 5'h00, seed[2:0], 2'h0, seed[4],
                    (k == 15) ? 1'b1 : seed[3], 4'(k)};
         adv_exp = 32'(exp_adv(4'(k)));
         i_rst <= 1'b0;
         repeat (4) @(posedge i_clk_sys);
         rd(`SCL_OFS_CFG, cfg_exp);
         rd(`SCL_OFS_ADV, adv_exp);
      end
      // Control hold only obeys lane 0 and can only force the clock off
      bus(1'b1, `SCL_OFS_CTRL, 32'h0000_0001, 4'he);
      rd(`SCL_OFS_CTRL, 32'h0000_0000);
      bus(1'b1, `SCL_OFS_CTRL, 32'h0000_0001, 4'h1);
      rd(`SCL_OFS_CTRL, 32'h0000_0001);
      cmp_bit("ref_clock_held", 1'b0, o_ref_clock_out_pin_en);
      bus(1'b1, `SCL_OFS_CFG, lfsr(seed), 4'hf);
      bus(1'b1, `SCL_OFS_ADV, ~seed, 4'hf);
      rd(`SCL_OFS_CFG, cfg_exp);
      rd(`SCL_OFS_ADV, adv_exp);
      rd(4'hc, 32'h0000_0000);
      bus(1'b1, `SCL_OFS_CTRL, 32'h0000_0000, 4'h1);
      rd(`SCL_OFS_CTRL, 32'h0000_0000);
      cmp_bit("ref_clock_released", 1'b1, o_ref_clock_out_pin_en);
      repeat (2) @(posedge i_clk_sys);
      cmp_word("pending_notes", 32'h0000_0000, 32'(rd_q.size() + cap_q.size()));
      complete_run();
   end
endmodule
